/* File: omci_core.sv */
// omci_core: management side of a four-lane optical module: lock-loss flags,
// recovery controls, lane codes, user page, init and pin timing.
// assumes: clk_i runs free; lclk_i is unrelated; bus pins have pull-ups.
`timescale 1ns/100ps
module omci_core
    import omci_pkg::*;
#(
    parameter int unsigned INIT_CYC = 32'(INIT_CYC_DEF) // init length
) (
    input wire logic clk_i, // system clock
    input wire logic reset_i, // sync reset, high
    input wire logic lclk_i, // link clock
    input wire logic scl_i, // bus clock level
    output logic scl_o, // bus clock drive value
    output logic scl_oe_o, // bus clock pulled low
    input wire logic sda_i, // bus data level
    output logic sda_o, // bus data drive value
    output logic sda_oe_o, // bus data pulled low
    input wire logic module_reset_n_i, // reset pin, low
    input wire logic low_power_pin_i, // low-power pin
    input wire logic [3:0] tx_lock_lost_i, // tx recovery unlocked
    input wire logic [3:0] rx_lock_lost_i, // rx recovery unlocked
    output logic interrupt_out_n_o, // interrupt, low
    output logic low_power_o, // low power level
    output logic [3:0] tx_recovery_on_o, // tx recovery on
    output logic [3:0] rx_recovery_on_o, // rx recovery on
    output logic [15:0] tx_eq_o, // tx equalization codes
    output logic [15:0] rx_emph_o, // rx emphasis codes
    output logic [15:0] rx_amp_o // rx amplitude codes
);
    logic [1:0] rpin_q;
    logic [1:0] lp_q;
    logic [7:0] lol_m_q;
    logic [7:0] lol_s_q;
    logic [6:0] low_cnt_q;
    logic mod_rst_q;
    logic srst;
    logic [26:0] init_cnt_q;
    logic dnr_q;
    logic ready_flag_q;
    logic init_end;
    logic [1:0] lrst_q;
    omci_req_t req;
    logic req_tgl;
    logic [2:0] rq_q;
    logic ack_tgl_q;
    logic [7:0] rdata_q;
    logic go;
    logic wr_go;
    logic rd_go;
    logic up;
    logic lane_hit;
    logic [2:0] lane_ofs;
    logic [7:0] rd_val;
    logic [7:0] flags_q;
    logic [7:0] cdr_q;
    logic [7:0] page_q;
    logic [7:0] user_mem [128];
    logic [3:0] nib_q [12];
    logic int_n_q;
    logic lp_on_q;
    logic od_q;
    logic [11:0] lp_wait_q;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rpin_q <= 2'h3;
            lp_q <= 2'h0;
            lol_m_q <= 8'h00;
            lol_s_q <= 8'h00;
        end else begin
            rpin_q <= {rpin_q[0], module_reset_n_i};
            lp_q <= {lp_q[0], low_power_pin_i};
            lol_m_q <= {tx_lock_lost_i, rx_lock_lost_i};
            lol_s_q <= lol_m_q;
        end
    end

    // ----------------------------------------
    // reset pin filter
    // ----------------------------------------
    // short glitches are ignored; only a held low restarts the module
    always_ff @(posedge clk_i) begin
        if (reset_i || rpin_q[1]) begin
            low_cnt_q <= 7'h00;
            mod_rst_q <= 1'b0;
        end else if (low_cnt_q == RST_MIN_CYC) begin
            mod_rst_q <= 1'b1;
        end else begin
            low_cnt_q <= low_cnt_q + 7'h01;
        end
    end

    assign srst = reset_i | mod_rst_q;

    // ----------------------------------------
    // initialisation timer
    // ----------------------------------------
    assign init_end = dnr_q && init_cnt_q == 27'(INIT_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (srst) begin
            init_cnt_q <= 27'h0000000;
            dnr_q <= 1'b1;
        end else if (init_end) begin
            dnr_q <= 1'b0;
        end else if (dnr_q) begin
            init_cnt_q <= init_cnt_q + 27'h0000001;
        end
    end

    // set wins over the clearing read of the status byte
    always_ff @(posedge clk_i) begin
        if (srst) begin
            ready_flag_q <= 1'b0;
        end else if (init_end) begin
            ready_flag_q <= 1'b1;
        end else if (rd_go && !up && req.addr == ADR_STATUS) begin
            ready_flag_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // link crossing
    // ----------------------------------------
    always_ff @(posedge lclk_i) begin
        lrst_q <= {lrst_q[0], reset_i};
    end

    omci_twi_slave u_twi (
        .lclk_i(lclk_i),
        .lrst_i(lrst_q[1]),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_oe_o(scl_oe_o),
        .sda_oe_o(sda_oe_o),
        .req_o(req),
        .req_tgl_o(req_tgl),
        .ack_tgl_i(ack_tgl_q),
        .rdata_i(rdata_q)
    );

    // payload is held by the slave until answered, so it is stable here
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rq_q <= 3'h0;
        end else begin
            rq_q <= {rq_q[1:0], req_tgl};
        end
    end

    assign go = rq_q[1] ^ rq_q[2];
    assign wr_go = go & req.wr;
    assign rd_go = go & ~req.wr;
    assign up = req.addr[7];
    assign lane_hit = up && page_q == PAGE_LANE && req.addr >= ADR_EQ
        && req.addr <= ADR_LANE_END;
    assign lane_ofs = 3'(req.addr - ADR_EQ);

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        rd_val = 8'h00;
        if (!up) begin
            case (req.addr)
                ADR_STATUS: rd_val = {7'h00, dnr_q};
                ADR_LOL: rd_val = flags_q;
                ADR_CDR: rd_val = cdr_q;
                ADR_PAGE: rd_val = page_q;
                default: rd_val = 8'h00;
            endcase
        end else if (page_q == PAGE_USER) begin
            rd_val = user_mem[req.addr[6:0]];
        end else if (lane_hit) begin
            rd_val = {nib_q[{lane_ofs, 1'b0}], nib_q[{lane_ofs, 1'b1}]};
        end
    end

    // every request is answered, so the slave's count stays in step
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
            ack_tgl_q <= 1'b0;
        end else if (go) begin
            rdata_q <= rd_val;
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst) begin
            cdr_q <= CDR_RST;
            page_q <= PAGE_RST;
        end else if (wr_go && !up) begin
            if (req.addr == ADR_CDR) begin
                cdr_q <= req.data;
            end
            if (req.addr == ADR_PAGE) begin
                page_q <= req.data;
            end
        end
    end

    assign tx_recovery_on_o = cdr_q[TX_LSB +: 4];
    assign rx_recovery_on_o = cdr_q[RX_LSB +: 4];

    // user page: plain storage, contents never looked at
    always_ff @(posedge clk_i) begin
        if (wr_go && up && page_q == PAGE_USER) begin
            user_mem[req.addr[6:0]] <= req.data;
        end
    end

    // ----------------------------------------
    // lane codes, one nibble per lane and field
    // ----------------------------------------
    for (genvar n = 0; n < 12; n++) begin : g_nib
        localparam int SH = (n % 2 == 0) ? 4 : 0;
        localparam logic [3:0] LIM = (n < 4) ? EQ_MAX : (n < 8) ? EMPH_MAX : AMP_MAX;
        logic [3:0] code;
        assign code = req.data[SH +: 4];
        always_ff @(posedge clk_i) begin
            if (srst) begin
                nib_q[n] <= CODE_RST;
            end else if (wr_go && lane_hit && lane_ofs == 3'(n / 2) && code <= LIM) begin
                nib_q[n] <= code;
            end
        end
        if (n < 4) begin : g_eq
            assign tx_eq_o[4 * n +: 4] = nib_q[n];
        end else if (n < 8) begin : g_emph
            assign rx_emph_o[4 * (n - 4) +: 4] = nib_q[n];
        end else begin : g_amp
            assign rx_amp_o[4 * (n - 8) +: 4] = nib_q[n];
        end
    end

    // ----------------------------------------
    // lock-loss flags and interrupt
    // ----------------------------------------
    // a loss in the clearing cycle survives the read
    always_ff @(posedge clk_i) begin
        if (srst) begin
            flags_q <= 8'h00;
        end else if (rd_go && !up && req.addr == ADR_LOL) begin
            flags_q <= lol_s_q;
        end else begin
            flags_q <= flags_q | lol_s_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst) begin
            int_n_q <= 1'b1;
        end else begin
            int_n_q <= ~(ready_flag_q | (|flags_q));
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            lp_on_q <= 1'b0;
            od_q <= 1'b0;
        end else begin
            lp_on_q <= lp_q[1];
            od_q <= 1'b0;
        end
    end

    assign interrupt_out_n_o = int_n_q;
    assign low_power_o = lp_on_q;
    assign scl_o = od_q;
    assign sda_o = od_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst);

    always_ff @(posedge clk_i) begin
        if (reset_i || !lp_q[1] || lp_on_q) begin
            lp_wait_q <= 12'h000;
        end else begin
            lp_wait_q <= lp_wait_q + 12'h001;
        end
    end

    sequence s_init_end;
        init_end;
    endsequence

    sequence s_pin_held;
        !rpin_q[1] ##0 low_cnt_q == RST_MIN_CYC;
    endsequence

    sequence s_lol_read;
        rd_go && !up && req.addr == ADR_LOL && lol_s_q == 8'h00;
    endsequence

    chk_tx_lol_set: assert property (
        lol_s_q[7:4] != 4'h0 |=> (flags_q[7:4] & $past(lol_s_q[7:4])) == $past(lol_s_q[7:4]))
        else $error("tx lock loss not latched");
    chk_rx_lol_set: assert property (
        lol_s_q[3:0] != 4'h0 |=> (flags_q[3:0] & $past(lol_s_q[3:0])) == $past(lol_s_q[3:0]))
        else $error("rx lock loss not latched");
    chk_tx_cdr_ctl: assert property (
        wr_go && !up && req.addr == ADR_CDR |=> tx_recovery_on_o == $past(req.data[7:4]))
        else $error("tx recovery control not applied");
    chk_rx_cdr_ctl: assert property (
        wr_go && !up && req.addr == ADR_CDR |=> rx_recovery_on_o == $past(req.data[3:0]))
        else $error("rx recovery control not applied");
    chk_amp_reserved: assert property (
        wr_go && lane_hit && req.addr == ADR_AMP && req.data[3:0] > AMP_MAX
        |=> $stable(rx_amp_o[7:4]))
        else $error("reserved amplitude code taken");
    chk_eq_reserved: assert property (
        wr_go && lane_hit && req.addr == ADR_EQ && req.data[7:4] > EQ_MAX
        |=> $stable(tx_eq_o[3:0]))
        else $error("reserved equalization code taken");
    chk_emph_reserved: assert property (
        wr_go && lane_hit && req.addr == ADR_EMPH && req.data[3]
        |=> $stable(rx_emph_o[7:4]))
        else $error("reserved emphasis code taken");
    chk_init_done: assert property (
        s_init_end |=> !dnr_q ##1 !interrupt_out_n_o)
        else $error("init end did not raise interrupt");
    chk_pin_reset: assert property (
        s_pin_held |=> mod_rst_q)
        else $error("held reset pin not honoured");
    chk_lp_entry: assert property (
        lp_wait_q < LP_CYC)
        else $error("low power entry too slow");
    chk_read_clear: assert property (
        s_lol_read |=> flags_q == 8'h00)
        else $error("lock-loss flags not cleared by read");
    chk_int_release: assert property (
        s_lol_read ##0 !ready_flag_q ##0 !dnr_q ##1 lol_s_q == 8'h00 |=> interrupt_out_n_o)
        else $error("interrupt not released after read");
endmodule

/* File: omci_pkg.sv */
// omci_pkg: constants and types shared by the management core and its bus slave.
// assumes: 40 MHz system clock; byte addresses of the two-wire register map.
package omci_pkg;
    // ----------------------------------------
    // bus address and register map
    // ----------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic [7:0] ADR_STATUS = 8'h02;
    localparam logic [7:0] ADR_LOL = 8'h05;
    localparam logic [7:0] ADR_CDR = 8'h62;
    localparam logic [7:0] ADR_PAGE = 8'h7F;
    localparam logic [7:0] ADR_EQ = 8'hEA;
    localparam logic [7:0] ADR_EMPH = 8'hEC;
    localparam logic [7:0] ADR_AMP = 8'hEE;
    localparam logic [7:0] ADR_LANE_END = 8'hEF;
    localparam logic [7:0] PAGE_USER = 8'h02;
    localparam logic [7:0] PAGE_LANE = 8'h03;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int TX_LSB = 4;
    localparam int RX_LSB = 0;
    localparam logic [7:0] CDR_RST = 8'h00;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [3:0] CODE_RST = 4'h0;
    localparam logic [3:0] EQ_MAX = 4'hA;
    localparam logic [3:0] EMPH_MAX = 4'h7;
    localparam logic [3:0] AMP_MAX = 4'h3;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam longint CLK_NS = 25;
    localparam longint T_INIT_MS = 2000;
    localparam longint INIT_CYC_DEF = T_INIT_MS * 1000000 / CLK_NS;
    localparam longint T_RST_NS = 2000;
    localparam logic [6:0] RST_MIN_CYC = 7'((T_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam longint T_LP_US = 100;
    localparam logic [11:0] LP_CYC = 12'(T_LP_US * 1000 / CLK_NS);
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } omci_req_t;
    typedef enum {
        TS_IDLE, TS_DEV, TS_PTR, TS_WDAT, TS_ACK, TS_FETCH, TS_RDAT, TS_RACK
    } omci_twi_st_t;
endpackage

/* File: omci_twi_slave.sv */
// omci_twi_slave: two-wire bus slave on the link clock; bytes go to the core
// as toggle-handshake requests.
// assumes: lclk_i far faster than the bus clock; reads stretch the bus clock.
`timescale 1ns/100ps
module omci_twi_slave
    import omci_pkg::*;
(
    input wire logic lclk_i, // link clock
    input wire logic lrst_i, // link reset, sync, high
    input wire logic scl_i, // bus clock level
    input wire logic sda_i, // bus data level
    output logic scl_oe_o, // hold bus clock low
    output logic sda_oe_o, // pull bus data low
    output omci_req_t req_o, // request payload, held
    output logic req_tgl_o, // toggles per request
    input wire logic ack_tgl_i, // answer toggle from core
    input wire logic [7:0] rdata_i // read byte, stable on answer
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] ack_q;
    omci_twi_st_t st_q;
    omci_twi_st_t nxt_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] ptr_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge lclk_i) begin
        if (lrst_i) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            ack_q <= 2'h0;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
            ack_q <= {ack_q[0], ack_tgl_i};
        end
    end

    assign rise = scl_q[1] & ~scl_q[2];
    assign fall = ~scl_q[1] & scl_q[2];
    assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

    // ----------------------------------------
    // byte engine
    // ----------------------------------------
    always_ff @(posedge lclk_i) begin
        if (lrst_i) begin
            st_q <= TS_IDLE;
            nxt_q <= TS_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            req_o <= '0;
            req_tgl_o <= 1'b0;
        end else if (start) begin
            st_q <= TS_DEV;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
        end else if (stop) begin
            st_q <= TS_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            case (st_q)
                TS_DEV, TS_PTR, TS_WDAT: begin
                    if (rise) begin
                        sh_q <= {sh_q[6:0], sda_q[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (fall && cnt_q == 4'h8) begin
                        cnt_q <= 4'h0;
                        st_q <= TS_ACK;
                        sda_oe_o <= 1'b1;
                        if (st_q == TS_DEV) begin
                            nxt_q <= sh_q[0] ? TS_FETCH : TS_PTR;
                            if (sh_q[7:1] != DEV_ADDR) begin
                                st_q <= TS_IDLE;
                                sda_oe_o <= 1'b0;
                            end
                        end else if (st_q == TS_PTR) begin
                            nxt_q <= TS_WDAT;
                            ptr_q <= sh_q;
                        end else begin
                            nxt_q <= TS_WDAT;
                            req_o <= '{wr: 1'b1, addr: ptr_q, data: sh_q};
                            req_tgl_o <= ~req_tgl_o;
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                end
                TS_ACK: if (fall) begin
                    sda_oe_o <= 1'b0;
                    st_q <= nxt_q;
                    if (nxt_q == TS_FETCH) begin
                        scl_oe_o <= 1'b1;
                        req_o <= '{wr: 1'b0, addr: ptr_q, data: 8'h00};
                        req_tgl_o <= ~req_tgl_o;
                    end
                end
                // bus clock held low until the core answers
                TS_FETCH: if (ack_q[1] == req_tgl_o) begin
                    sh_q <= rdata_i;
                    sda_oe_o <= ~rdata_i[7];
                    cnt_q <= 4'h1;
                    ptr_q <= ptr_q + 8'h01;
                    scl_oe_o <= 1'b0;
                    st_q <= TS_RDAT;
                end
                TS_RDAT: if (fall) begin
                    if (cnt_q == 4'h8) begin
                        sda_oe_o <= 1'b0;
                        st_q <= TS_RACK;
                    end else begin
                        sda_oe_o <= ~sh_q[6];
                        sh_q <= {sh_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                TS_RACK: begin
                    if (rise && sda_q[1]) begin
                        st_q <= TS_IDLE;
                    end else if (fall) begin
                        st_q <= TS_FETCH;
                        scl_oe_o <= 1'b1;
                        req_o <= '{wr: 1'b0, addr: ptr_q, data: 8'h00};
                        req_tgl_o <= ~req_tgl_o;
                    end
                end
                default: st_q <= TS_IDLE;
            endcase
        end
    end
endmodule

/* File: omci_host_model.sv */
// host side: two-wire bus master.
// assumes: pull-ups on both lines; moves on clk_i falls.
`timescale 1ns/100ps
module omci_host_model
    import omci_pkg::*;
(
    input wire logic clk_i, // bench clock
    input wire logic scl_i, // clock line
    input wire logic sda_i, // data line
    output logic scl_low_o = 1'b0, // pull clock low
    output logic sda_low_o = 1'b0 // pull data low
);
    task automatic pins(input logic c, input logic d);
        scl_low_o = c;
        sda_low_o = d;
        repeat (4) @(negedge clk_i);
    endtask
    // slave may stretch the clock before a read byte; bounded wait
    task automatic bit_x(input logic b, output logic s);
        pins(1'b1, ~b);
        scl_low_o = 1'b0;
        for (int n = 0; n < 200 && scl_i !== 1'b1; n++)
            @(negedge clk_i);
        repeat (4) @(negedge clk_i);
        s = sda_i;
        scl_low_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic start();
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r[i]);
        bit_x(1'b1, ak);
    endtask
    task automatic xact(input logic rw, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r, output logic [2:0] nak);
        logic ak;
        start();
        xfer({DEV_ADDR, 1'b0}, r, nak[2]);
        xfer(a, r, nak[1]);
        if (rw) begin
            start();
            xfer({DEV_ADDR, 1'b1}, r, nak[0]);
            xfer(8'hFF, r, ak);
        end else begin
            xfer(d, r, nak[0]);
        end
        pins(1'b1, 1'b1);
        pins(1'b0, 1'b1);
        pins(1'b0, 1'b0);
    endtask
endmodule

/* File: omci_core_tb_top.sv */
// bench for omci_core; the host model drives the bus.
// assumes: omci_pkg and omci_host_model compiled first.
`timescale 1ns/100ps
module omci_core_tb_top;
    import omci_pkg::*;
    localparam int unsigned INIT = 2000;
    localparam logic [63:0] LANES [7] = '{64'hEAA3_003A_0000_0000, 64'hEAB5_005A_0000_0000,
        64'hEBC1_105A_0000_0000, 64'hEC78_105A_0007_0000, 64'hED96_105A_6007_0000,
        64'hEE34_105A_6007_0003, 64'hEF12_105A_6007_2103};
    logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, rst_n = 1'b1, lp = 1'b0;
    logic [3:0] txl = 4'h0, rxl = 4'h0, txon, rxon;
    logic scl_low, sda_low, scl_oe, sda_oe, int_n, lp_o;
    logic scl_d, sda_d;
    logic [15:0] eq, emph, amp;
    wire scl = ~(scl_low | scl_oe), sda = ~(sda_low | sda_oe);
    int n_mismatch = 0, check_count = 0;
    always #12.5 clk = ~clk;
    always #6 lclk = ~lclk;
    omci_core #(.INIT_CYC(INIT)) omci_core_i (.clk_i(clk), .reset_i(rst), .lclk_i(lclk),
        .scl_i(scl), .scl_o(scl_d), .scl_oe_o(scl_oe),
        .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe),
        .module_reset_n_i(rst_n), .low_power_pin_i(lp), .tx_lock_lost_i(txl),
        .rx_lock_lost_i(rxl), .interrupt_out_n_o(int_n), .low_power_o(lp_o),
        .tx_recovery_on_o(txon), .rx_recovery_on_o(rxon), .tx_eq_o(eq), .rx_emph_o(emph),
        .rx_amp_o(amp));
    omci_host_model omci_host_model_i (.clk_i(clk), .scl_i(scl), .sda_i(sda),
        .scl_low_o(scl_low), .sda_low_o(sda_low));
    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic rw, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic [2:0] nak;
        omci_host_model_i.xact(rw, a, d, r, nak);
        chk("bus", {37'h0, rw ? d : 8'h00, 3'h0}, {37'h0, rw ? r : 8'h00, nak});
    endtask
    task automatic wait_int(input logic v, input int lim);
        for (int n = 0; n < lim && int_n !== v; n++)
            @(negedge clk);
        chk("int", {47'h0, v}, {47'h0, int_n});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // traffic needs about 12k cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (6) @(negedge clk);
        chk("reset", 48'h1, {20'h0, scl_d, sda_d, eq | emph | amp, txon, rxon, lp_o, int_n});
        rst = 1'b0;
        acc(1'b1, ADR_CDR, CDR_RST);
        wait_int(1'b0, INIT);
        acc(1'b1, ADR_STATUS, 8'h00);
        wait_int(1'b1, 20);
        acc(1'b1, 8'h03, 8'h00);
        acc(1'b0, ADR_CDR, 8'hA5);
        acc(1'b1, ADR_CDR, 8'hA5);
        chk("recovery", 48'hA5, {40'h0, txon, rxon});
        for (int i = 0; i < 4; i++) begin
            txl = 4'(1 << i);
            rxl = 4'(8 >> i);
            wait_int(1'b0, 8);
            {txl, rxl} = 8'h00;
            acc(1'b1, ADR_LOL, 8'(8'h10 << i) | 8'(8'h08 >> i));
            wait_int(1'b1, 20);
        end
        rxl = 4'h2;
        acc(1'b1, ADR_LOL, 8'h02);
        rxl = 4'h0;
        acc(1'b1, ADR_LOL, 8'h02);
        wait_int(1'b1, 20);
        acc(1'b0, ADR_PAGE, PAGE_LANE);
        for (int k = 0; k < 7; k++) begin
            acc(1'b0, LANES[k][63:56], LANES[k][55:48]);
            chk("lanes", LANES[k][47:0], {eq, emph, amp});
        end
        acc(1'b0, ADR_PAGE, PAGE_USER);
        acc(1'b0, 8'h80, 8'h5A);
        acc(1'b1, 8'h80, 8'h5A);
        lp = 1'b1;
        repeat (4) @(negedge clk);
        chk("low power", 48'h1, {45'h0, scl_d, sda_d, lp_o});
        rst_n = 1'b0;
        repeat (90) @(negedge clk);
        chk("pin reset", 48'h1, {39'h0, txon, rxon, int_n});
        rst_n = 1'b1;
        wait_int(1'b0, INIT + 100);
        stop_test();
    end
endmodule
